/* File: core/parallel_output_port_strobe.sv */
// Port A pin seven, port B and the read/write or strobe B pin
`timescale 1ns/10ps
module parallel_output_port_strobe
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic expanded_mode_select_i,
  input wire logic [7:0] high_address_i,
  input wire logic bus_read_write_i,
  input wire logic compare_one_match_i,
  input wire logic input_strobe_a_i,
  input wire logic port_a_pin_seven_i,
  output logic port_a_pin_seven_o,
  output logic port_a_pin_seven_oe_o,
  output logic [7:0] port_b_o,
  output logic output_strobe_b_o,
  output logic address_latch_strobe_o,
  output logic e_clock_o,
  output logic port_b_read_enable_o,
  output logic port_c_latched_read_o,
  output logic port_c_latched_write_o
);
  import port_out_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  phase_s phase;
  logic wr_en;
  logic rd_en;
  logic port_b_write_strobe;
  logic port_b_read;
  logic ctrl_write;

  // Bus decode helper for one register offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  phase_divider u_phase
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .phase_o(phase)
  );

  // Single access cycle, no wait states; unmapped addresses give pslverr
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // In expanded mode port B belongs to the external bus
  assign port_b_write_strobe = wr_en && hit(paddr, PORT_B_OFFSET) && !expanded_mode_select_i;
  assign port_b_read = rd_en && hit(paddr, PORT_B_OFFSET) && !expanded_mode_select_i;
  assign port_b_read_enable_o = port_b_read;
  assign port_c_latched_read_o = rd_en && hit(paddr, PORT_C_LATCHED_OFFSET);
  assign port_c_latched_write_o = wr_en && hit(paddr, PORT_C_LATCHED_OFFSET);
  assign ctrl_write = wr_en && hit(paddr, PARALLEL_CTRL_OFFSET);
  assign e_clock_o = phase.e_high;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [4:0] parallel_io_control_reg;
  logic pin7_direction_bit;
  logic pin7_direction_reg;
  logic timer_override_mask_pin7;
  logic timer_override_data_pin7;
  logic port_a_latch_reg;
  logic force_pending_reg;
  logic match_pending_reg;
  logic handshake_enable;
  logic handshake_direction;
  logic pulse_mode_select;
  logic strobe_b_polarity;
  strobe_mode_e strobe_mode;

  assign handshake_enable = parallel_io_control_reg[HANDSHAKE_ENABLE_BIT];
  assign handshake_direction = parallel_io_control_reg[OIN_BIT];
  assign pulse_mode_select = parallel_io_control_reg[PLS_BIT];
  assign strobe_b_polarity = parallel_io_control_reg[STROBE_B_POLARITY_BIT];

  // Parallel control register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      parallel_io_control_reg <= CTRL_RESET;
    else if (ctrl_write)
      parallel_io_control_reg <= pwdata[4:0];
  end

  // Port A direction, timer mask and timer data as written
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin7_direction_bit <= 1'b0;
      timer_override_mask_pin7 <= 1'b0;
      timer_override_data_pin7 <= 1'b0;
    end
    else
    begin
      if (wr_en && hit(paddr, PORT_A_CTRL_OFFSET))
        pin7_direction_bit <= pwdata[DIR7_BIT];
      if (wr_en && hit(paddr, TIMER_CTRL_OFFSET))
      begin
        timer_override_mask_pin7 <= pwdata[MASK7_BIT];
        timer_override_data_pin7 <= pwdata[DATA7_BIT];
      end
    end
  end

  // General port A latch, cleared at reset
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      port_a_latch_reg <= 1'b0;
    else if (wr_en && hit(paddr, PORT_A_OFFSET))
      port_a_latch_reg <= pwdata[7];
  end

  // Compare and force events wait for the next E fall; a new event wins over the clear
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      force_pending_reg <= 1'b0;
      match_pending_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && hit(paddr, TIMER_CTRL_OFFSET) && pwdata[FORCE_BIT])
        force_pending_reg <= 1'b1;
      else if (phase.e_fall)
        force_pending_reg <= 1'b0;
      if (compare_one_match_i)
        match_pending_reg <= 1'b1;
      else if (phase.e_fall)
        match_pending_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A pin seven

  // Pin data changes only at the E fall
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      port_a_pin_seven_o <= 1'b0;
    else if (phase.e_fall)
    begin
      if (!timer_override_mask_pin7)
        port_a_pin_seven_o <= port_a_latch_reg;
      else if (force_pending_reg || match_pending_reg)
        port_a_pin_seven_o <= timer_override_data_pin7;
    end
  end

  // Direction takes effect at the phase-two fall
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pin7_direction_reg <= 1'b0;
    else if (phase.ph2_fall)
      pin7_direction_reg <= pin7_direction_bit;
  end

  assign port_a_pin_seven_oe_o = pin7_direction_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Port B

  logic [7:0] output_port_b_reg;
  logic [7:0] port_b_pending_reg;
  logic port_b_update_reg;
  logic address_latch_strobe_reg;
  logic read_write_latch_reg;

  // Address strobe high from phase-two rise to E rise, so the address holds one quarter past E fall
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      address_latch_strobe_reg <= 1'b0;
    else if (phase.ph2_rise || phase.e_rise)
      address_latch_strobe_reg <= phase.ph2_rise;
  end
  assign address_latch_strobe_o = address_latch_strobe_reg;

  // Write data waits for the phase-two fall, so a read cycle never sees a change
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_b_pending_reg <= PORT_B_RESET;
      port_b_update_reg <= 1'b0;
    end
    else if (port_b_write_strobe)
    begin
      port_b_pending_reg <= pwdata[7:0];
      port_b_update_reg <= 1'b1;
    end
    else if (phase.ph2_fall && !port_b_read)
      port_b_update_reg <= 1'b0;
  end

  // Output latch: write data or transparent high address
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      output_port_b_reg <= PORT_B_RESET;
    else if (expanded_mode_select_i)
    begin
      // Held through E fall and the following quarter until strobe rises
      if (address_latch_strobe_reg)
        output_port_b_reg <= high_address_i;
    end
    else if (phase.ph2_fall && port_b_update_reg && !port_b_read)
      output_port_b_reg <= port_b_pending_reg;
  end

  assign port_b_o = output_port_b_reg;

  // Read/write latch shares address timing
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      read_write_latch_reg <= 1'b1;
    else if (address_latch_strobe_reg)
      read_write_latch_reg <= bus_read_write_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe B

  logic strobe_latch_reg;
  logic start_pending_reg;
  logic end_pending_reg;
  logic [1:0] strobe_count_reg;
  logic strobe_a_prev_reg;
  logic strobe_a_edge;
  logic strobe_b_begin;
  logic strobe_b_finish;
  logic start_event;

  // Mode select from handshake and direction bits
  always_comb
  begin
    if (!handshake_enable)
      strobe_mode = SIMPLE_STROBE;
    else if (handshake_direction)
      strobe_mode = OUTPUT_HANDSHAKE;
    else
      strobe_mode = INPUT_HANDSHAKE;
  end

  // Start events by mode
  always_comb
  begin
    start_event = 1'b0;
    unique case (strobe_mode)
      SIMPLE_STROBE: start_event = port_b_write_strobe;
      INPUT_HANDSHAKE: start_event = port_c_latched_read_o;
      OUTPUT_HANDSHAKE: start_event = port_c_latched_write_o;
    endcase
  end

  // Strobe A edge sensed per the selected edge bit
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      strobe_a_prev_reg <= 1'b0;
    else
      strobe_a_prev_reg <= input_strobe_a_i;
  end
  assign strobe_a_edge = (input_strobe_a_i != strobe_a_prev_reg) &&
    (input_strobe_a_i == parallel_io_control_reg[EGA_BIT]);

  // Pending start and end requests, released at the phase-two rise
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_pending_reg <= 1'b0;
      end_pending_reg <= 1'b0;
    end
    else
    begin
      if (start_event)
        start_pending_reg <= 1'b1;
      else if (phase.ph2_rise)
        start_pending_reg <= 1'b0;
      if (strobe_latch_reg && handshake_enable && !pulse_mode_select && strobe_a_edge)
        end_pending_reg <= 1'b1;
      else if (ctrl_write && pwdata[HANDSHAKE_ENABLE_BIT] && pwdata[PLS_BIT] && strobe_latch_reg)
        end_pending_reg <= 1'b1;
      else if (phase.ph2_rise)
        end_pending_reg <= 1'b0;
    end
  end

  assign strobe_b_begin = phase.ph2_rise && start_pending_reg;
  // Timed end after two E periods unless interlocked; a pending end request ends it at the next rise
  assign strobe_b_finish = phase.ph2_rise && strobe_latch_reg && (end_pending_reg ||
    ((!handshake_enable || pulse_mode_select) && strobe_count_reg == STROBE_E_PERIODS));

  // Period count of the active strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      strobe_count_reg <= 2'h0;
    else if (strobe_b_begin)
      strobe_count_reg <= 2'h1;
    else if (phase.ph2_rise && strobe_latch_reg && strobe_count_reg != STROBE_E_PERIODS)
      strobe_count_reg <= strobe_count_reg + 2'h1;
  end

  // Strobe latch; a new start wins over a finish in the same edge
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      strobe_latch_reg <= 1'b0;
    else if (strobe_b_begin)
      strobe_latch_reg <= 1'b1;
    else if (strobe_b_finish)
      strobe_latch_reg <= 1'b0;
  end

  // Pin: latched read/write in expanded mode, strobe with chosen polarity otherwise
  always_comb
  begin
    if (expanded_mode_select_i)
      output_strobe_b_o = read_write_latch_reg;
    else if (strobe_b_polarity)
      output_strobe_b_o = strobe_latch_reg;
    else
      output_strobe_b_o = !strobe_latch_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  // Read mux; port B returns buffer in single-chip and zero in expanded mode, pin seven returns sensed level
  always_comb
  begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (hit(paddr, PORT_A_OFFSET))
      prdata[7] = port_a_pin_seven_i;
    else if (hit(paddr, PORT_B_OFFSET))
      prdata[7:0] = expanded_mode_select_i ? 8'h00 : output_port_b_reg;
    else if (hit(paddr, PORT_C_LATCHED_OFFSET))
      prdata = 32'h0000_0000;
    else if (hit(paddr, PARALLEL_CTRL_OFFSET))
      prdata[4:0] = parallel_io_control_reg;
    else if (hit(paddr, PORT_A_CTRL_OFFSET))
      prdata[DIR7_BIT] = pin7_direction_bit;
    else if (hit(paddr, TIMER_CTRL_OFFSET))
      prdata[1:0] = {timer_override_mask_pin7, timer_override_data_pin7};
    else if (hit(paddr, STATUS_OFFSET))
      prdata[1:0] = {strobe_latch_reg, port_b_update_reg};
    else
      pslverr = psel && penable;
  end
endmodule

/* File: core/port_out_pkg.sv */
// Package for the parallel output port and strobe B block
// Summary of operation
// - Direction bit one drives pin seven; zero leaves it as input only.
// - Mask zero: pin seven follows a general latch loaded by writes, reset to zero.
// - Mask one: timer data bit copied to pin on compare match or force.
// - Port A pins change at E fall; direction changes at phase-two fall.
// - Port B pins are always outputs: address in expanded, data otherwise.
// - Expanded mode: port B accesses go external, internal read enable stays low.
// - Single-chip port B read returns the last value written, not the pin.
// - Single-chip port B write latches bus data; reset drives pins to zero.
// - Expanded: high address latch transparent while address strobe high.
// - Port B write updates pins at phase-two fall; never changes during a read.
// - Expanded: high address held one quarter cycle after E falls.
// - Expanded: strobe pin carries latched read/write; single-chip carries strobe B.
// - Polarity bit zero gives active-low strobe B; one gives active high.
// - Handshake off selects simple strobe; on, direction picks input or output handshake.
// - Simple strobe starts at phase-two rise after a port B write.
// - Input handshake starts strobe at phase-two rise after latched-data read.
// - Output handshake starts strobe at phase-two rise after latched-data write.
// - Handshake off or pulse mode: strobe ends two E periods after start.
// - Interlocked: partner gives strobe A edge; strobe ends at next phase-two rise.
// - Pulse and handshake bits written one during active strobe end it at next phase-two rise.
// - Port A bit seven reads always return the sensed pin level.
package port_out_pkg;

  // Byte offsets of the APB registers
  localparam logic [7:0] PORT_A_OFFSET = 8'h00;
  localparam logic [7:0] PORT_B_OFFSET = 8'h04;
  localparam logic [7:0] PORT_C_LATCHED_OFFSET = 8'h08;
  localparam logic [7:0] PARALLEL_CTRL_OFFSET = 8'h0C;
  localparam logic [7:0] PORT_A_CTRL_OFFSET = 8'h10;
  localparam logic [7:0] TIMER_CTRL_OFFSET = 8'h14;
  localparam logic [7:0] STATUS_OFFSET = 8'h18;

  // Parallel control register fields
  localparam int HANDSHAKE_ENABLE_BIT = 4;
  localparam int OIN_BIT = 3;
  localparam int PLS_BIT = 2;
  localparam int EGA_BIT = 1;
  localparam int STROBE_B_POLARITY_BIT = 0;
  // Port A control and timer control fields
  localparam int DIR7_BIT = 7;
  localparam int MASK7_BIT = 1;
  localparam int DATA7_BIT = 0;
  localparam int FORCE_BIT = 2;

  localparam logic [7:0] PORT_B_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Quarter-E phase counter; E period is four quarters of QUARTER_CYCLES clocks
  localparam int QUARTER_NS = 40;
  localparam int CLK_NS = 10;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PH_E_RISE = 2'h0;
  localparam logic [1:0] PH_PH2_FALL = 2'h1;
  localparam logic [1:0] PH_E_FALL = 2'h2;
  localparam logic [1:0] PH_PH2_RISE = 2'h3;
  // Strobe length in phase-two rises: two full E periods
  localparam logic [1:0] STROBE_E_PERIODS = 2'h2;

  typedef enum logic [1:0] {SIMPLE_STROBE, INPUT_HANDSHAKE, OUTPUT_HANDSHAKE} strobe_mode_e;

  // Phase enables carried together
  typedef struct packed {
    logic e_rise;
    logic ph2_fall;
    logic e_fall;
    logic ph2_rise;
    logic e_high;
  } phase_s;

endpackage

/* File: core/phase_divider.sv */
// Divider that makes E and phase-two edge enables
`timescale 1ns/10ps
module phase_divider
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  output port_out_pkg::phase_s phase_o
);
  import port_out_pkg::*;

  logic [7:0] tick_reg;
  logic [1:0] quarter_reg;
  logic quarter_end;

  assign quarter_end = (tick_reg == 8'(QUARTER_CYCLES - 1));

  // Clock-cycle count inside one quarter of E
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      tick_reg <= 8'h00;
    else if (quarter_end)
      tick_reg <= 8'h00;
    else
      tick_reg <= tick_reg + 8'h01;
  end

  // Quarter index: four per E period
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      quarter_reg <= 2'h0;
    else if (quarter_end)
      quarter_reg <= quarter_reg + 2'h1;
  end

  // One-cycle enables at each quarter boundary, E high during quarters 0 and 1
  always_comb
  begin
    phase_o.e_rise = quarter_end && (quarter_reg == PH_PH2_RISE);
    phase_o.ph2_fall = quarter_end && (quarter_reg == PH_E_RISE);
    phase_o.e_fall = quarter_end && (quarter_reg == PH_PH2_FALL);
    phase_o.ph2_rise = quarter_end && (quarter_reg == PH_E_FALL);
    phase_o.e_high = (quarter_reg == PH_E_RISE) || (quarter_reg == PH_PH2_FALL);
  end
endmodule

/* File: verif/port_out_checker_sva.sv */
// Checker for pin timing and cause of the strobe and port enables
`timescale 1ns/10ps
module port_out_checker
  import port_out_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic expanded_mode_select_i,
  input wire logic port_a_pin_seven_o,
  input wire logic port_a_pin_seven_oe_o,
  input wire logic [7:0] port_b_o,
  input wire logic output_strobe_b_o,
  input wire logic address_latch_strobe_o,
  input wire logic e_clock_o,
  input wire logic port_b_read_enable_o,
  input wire logic port_c_latched_read_o,
  input wire logic port_c_latched_write_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Expanded mode with the address strobe low for two samples: latch closed
  sequence latch_closed;
    expanded_mode_select_i && $past(expanded_mode_select_i) &&
      !address_latch_strobe_o && !$past(address_latch_strobe_o);
  endsequence
  // High address steady over the two samples after E falls
  sequence addr_steady_two;
    $stable(port_b_o) ##1 $stable(port_b_o);
  endsequence

  oe_mid_high_a: assert property ($changed(port_a_pin_seven_oe_o) |-> e_clock_o)
    else $error("pin seven enable moved outside E high");
  pin7_e_fall_a: assert property ($changed(port_a_pin_seven_o) |-> ##[0:1] !e_clock_o)
    else $error("pin seven data moved away from E fall");
  output_port_b_reg_mid_high_a: assert property
    (!expanded_mode_select_i && $changed(port_b_o) |-> e_clock_o)
    else $error("port B moved outside E high");
  output_port_b_reg_read_still_a: assert property (port_b_read_enable_o |=> $stable(port_b_o))
    else $error("port B moved during a read");
  rden_expanded_a: assert property (expanded_mode_select_i |-> !port_b_read_enable_o)
    else $error("port B read enable in expanded mode");
  rden_cause_a: assert property (port_b_read_enable_o |->
    psel && penable && !pwrite && paddr == PORT_B_OFFSET)
    else $error("port B read enable without a port B read");
  addr_hold_a: assert property (latch_closed |-> $stable(port_b_o))
    else $error("high address moved while latch closed");
  addr_fall_hold_a: assert property
    (expanded_mode_select_i && $fell(e_clock_o) |-> addr_steady_two)
    else $error("high address moved too soon after E fell");
  rw_hold_a: assert property (latch_closed |-> $stable(output_strobe_b_o))
    else $error("read write pin moved while latch closed");
  cwr_cause_a: assert property (port_c_latched_write_o |->
    psel && penable && pwrite && paddr == PORT_C_LATCHED_OFFSET)
    else $error("latched write pulse without its write");
  crd_cause_a: assert property (port_c_latched_read_o |->
    psel && penable && !pwrite && paddr == PORT_C_LATCHED_OFFSET)
    else $error("latched read pulse without its read");
  output_port_b_reg_reset_a: assert property ($fell(rst_i) |-> port_b_o == PORT_B_RESET)
    else $error("port B not zero after reset");
endmodule

bind parallel_output_port_strobe port_out_checker u_chk (.*);

/* File: verif/strobe_peer.sv */
// Far-side peripheral that answers strobe B with a strobe A pulse
`timescale 1ns/10ps
module strobe_peer
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic strobe_b_i,
  input wire logic active_level_i,
  input wire logic enable_i,
  output logic strobe_a_o
);
  int wait_cnt;

  // Slow answer: both edges appear, so either selected edge is offered
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_cnt <= 0;
      strobe_a_o <= 1'b0;
    end
    else
    begin
      wait_cnt <= (enable_i && strobe_b_i == active_level_i) ? wait_cnt + 1 : 0;
      strobe_a_o <= enable_i && wait_cnt >= 48 && wait_cnt < 56;
    end
  end
endmodule

/* File: verif/parallel_output_port_strobe_tb.sv */
// Self-checking bench for the output port and strobe B block
`timescale 1ns/10ps
module parallel_output_port_strobe_tb;
  import port_out_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, exp_m, rw, cmp, ext_lvl;
  logic [7:0] paddr, hi_addr, port_b;
  logic [31:0] pwdata, prdata, r;
  logic pin_o, pin_oe, pin_in, output_strobe_b, str_a, peer_en, act, e;
  int num_errors, n_checks, d, l;
  logic [7:0] ctl_tab [4] = '{8'h00, 8'h01, 8'h14, 8'h1C};

  assign pin_in = pin_oe ? pin_o : ext_lvl;

  parallel_output_port_strobe u_dut (.core_clk_i(clk), .rst_i(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .expanded_mode_select_i(exp_m),
    .high_address_i(hi_addr), .bus_read_write_i(rw), .compare_one_match_i(cmp),
    .input_strobe_a_i(str_a), .port_a_pin_seven_i(pin_in), .port_a_pin_seven_o(pin_o),
    .port_a_pin_seven_oe_o(pin_oe), .port_b_o(port_b), .output_strobe_b_o(output_strobe_b),
    .address_latch_strobe_o(), .e_clock_o(), .port_b_read_enable_o(),
    .port_c_latched_read_o(), .port_c_latched_write_o());
  strobe_peer u_peer (.core_clk_i(clk), .rst_i(rst), .strobe_b_i(output_strobe_b),
    .active_level_i(act), .enable_i(peer_en), .strobe_a_o(str_a));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and shared tasks
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; pready, read data and pslverr are taken at the same rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    while (rdy !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      rdy = pready;
      r = prdata;
      e = pslverr;
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1)
    begin
      num_errors++;
      report_and_stop();
    end
    @(posedge clk);
  endtask

  // Cycles until strobe B turns active, then cycles it stays active
  task meas;
    d = 0;
    l = 0;
    while (output_strobe_b !== act && d < 60)
    begin
      @(posedge clk);
      d++;
    end
    while (output_strobe_b === act && l < 300)
    begin
      @(posedge clk);
      l++;
    end
    // A strobe that never starts or never ends is a hang
    if (d >= 60 || l >= 300)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_modes;
    for (int i = 0; i < 4; i++)
    begin
      act = ctl_tab[i][STROBE_B_POLARITY_BIT];
      apb(1'b1, PARALLEL_CTRL_OFFSET, {24'h0, ctl_tab[i]});
      cyc(20);
      chk(output_strobe_b, !act);
      if (i == 2)
      begin
        apb(1'b1, PORT_B_OFFSET, 32'h5A);
        cyc(50);
        chk(output_strobe_b, !act);
      end
      if (i < 2)
        apb(1'b1, PORT_B_OFFSET, 32'hA5 ^ i);
      else
        apb(i == 3, PORT_C_LATCHED_OFFSET, 32'h0);
      meas();
      chk(d <= 17, 1);
      chk(l, 32);
      if (i < 2)
      begin
        chk(port_b, 8'hA5 ^ i);
        apb(1'b0, PORT_B_OFFSET, 32'h0);
        chk(r[7:0], 8'hA5 ^ i);
      end
    end
    $display("modes test done");
  endtask

  task t_interlock;
    act = 1'b0;
    peer_en <= 1'b1;
    apb(1'b1, PARALLEL_CTRL_OFFSET, 32'h1A);
    apb(1'b1, PORT_C_LATCHED_OFFSET, 32'h0);
    meas();
    chk(l > 48 && l <= 73, 1);
    peer_en <= 1'b0;
    apb(1'b1, PORT_C_LATCHED_OFFSET, 32'h0);
    cyc(20);
    chk(output_strobe_b, act);
    apb(1'b1, PARALLEL_CTRL_OFFSET, 32'h1E);
    d = 0;
    l = 0;
    meas();
    chk(l <= 17, 1);
    $display("interlock test done");
  endtask

  task t_pin7;
    apb(1'b1, PORT_A_CTRL_OFFSET, 32'h80);
    apb(1'b1, PORT_A_OFFSET, 32'h80);
    cyc(20);
    chk({pin_oe, pin_o}, 2'b11);
    apb(1'b1, PORT_A_CTRL_OFFSET, 32'h00);
    cyc(20);
    chk(pin_oe, 1'b0);
    apb(1'b0, PORT_A_OFFSET, 32'h0);
    chk(r[7], ext_lvl);
    apb(1'b1, PORT_A_CTRL_OFFSET, 32'h80);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h02);
    cyc(20);
    chk(pin_o, 1'b1);
    cmp <= 1'b1;
    @(posedge clk);
    cmp <= 1'b0;
    cyc(20);
    chk(pin_o, 1'b0);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h07);
    cyc(20);
    chk(pin_o, 1'b1);
    $display("pin seven test done");
  endtask

  task t_expanded;
    exp_m <= 1'b1;
    hi_addr <= 8'h3C;
    rw <= 1'b0;
    cyc(40);
    chk(port_b, 8'h3C);
    chk(output_strobe_b, 1'b0);
    apb(1'b0, PORT_B_OFFSET, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(e, 1'b1);
    $display("expanded test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    num_errors = 0;
    n_checks = 0;
    {rst, psel, penable, pwrite, exp_m, cmp, peer_en, act} = 8'h80;
    {rw, ext_lvl} = 2'b10;
    paddr = 8'h00;
    pwdata = 32'h0;
    hi_addr = 8'h00;
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    chk({port_b, output_strobe_b, pin_oe}, 10'h002);
    t_modes();
    t_interlock();
    t_pin7();
    t_expanded();
    report_and_stop();
  end
endmodule
